// File: rtl/ccr_regs.sv
// Purpose: Clock correction and startup configuration registers behind AXI4-Lite
// Assumes: CONFIG_ACTIVE and DOUBLE_CYCLE_START come from logic on CLOCK
// Notes:   Locked registers ignore writes outside configuration
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - 16-bit external rate correction magnitude register
// - Rate magnitude writable only in configuration
// - Bit 0 enables external offset correction
// - Offset correction applied once, then self-clears
// - Bit 1 offset sign: 0 add, 1 subtract
// - Bit 2 rate enable, applied once, self-clears
// - Bit 3 rate sign: 0 add, 1 subtract
// - Clamp internal offset correction to limit
// - Clamp internal rate correction to limit
// - Limits never restrict external correction terms
// - Count coldstart attempts against programmed maximum
// - Limit reached: listen until configuration re-entered
// - Zero limit forbids starting communication
// - Low byte: transmit start sequence length
// - High byte: receive maximum, config-locked
// - 4-bit vector length, reset zero, locked
// - 16-bit external offset correction magnitude register
module ccr_regs
   import ccr_pkg::*;
(
   input  wire logic                     CLOCK,
   input  wire logic                     RST_B,
   input  wire logic [ADDR_W-1:0]        AWADDR,
   input  wire logic                     AWVALID,
   output logic                          AWREADY,
   input  wire logic [DATA_W-1:0]        WDATA,
   input  wire logic [DATA_W/8-1:0]      WSTRB,
   input  wire logic                     WVALID,
   output logic                          WREADY,
   output logic [1:0]                    BRESP,
   output logic                          BVALID,
   input  wire logic                     BREADY,
   input  wire logic [ADDR_W-1:0]        ARADDR,
   input  wire logic                     ARVALID,
   output logic                          ARREADY,
   output logic [DATA_W-1:0]             RDATA,
   output logic [1:0]                    RRESP,
   output logic                          RVALID,
   input  wire logic                     RREADY,
   input  wire logic                     CONFIG_ACTIVE,
   input  wire logic                     DOUBLE_CYCLE_START,
   input  wire logic signed [CORR_W-1:0] INT_OFFSET_CORR,
   input  wire logic signed [CORR_W-1:0] INT_RATE_CORR,
   input  wire logic                     COLDSTART_ATTEMPT,
   input  wire logic                     VALID_RESPONSE,
   output logic signed [SUM_W-1:0]       OFFSET_CORR,
   output logic signed [SUM_W-1:0]       RATE_CORR,
   output logic                          CORR_VALID,
   output logic                          COLDSTART_ALLOWED,
   output logic                          INTEGRATION_LISTEN,
   output logic                          COMM_ALLOWED,
   output logic [TSS_W-1:0]              START_SEQ_TX_LEN,
   output logic [TSS_W-1:0]              START_SEQ_RX_MAX,
   output logic [NM_LEN_W-1:0]           NM_VECTOR_LEN
);

   // Bus handshake state
   logic                    awready_reg;
   logic                    wready_reg;
   logic                    bvalid_reg;
   logic [1:0]              bresp_reg;
   logic                    arready_reg;
   logic                    rvalid_reg;
   logic [1:0]              rresp_reg;
   logic [DATA_W-1:0]       rdata_reg;

   // Register storage
   logic [REG_W-1:0]        ext_offset_reg;
   logic [REG_W-1:0]        ext_rate_reg;
   logic [REG_W-1:0]        offset_limit_reg;
   logic [REG_W-1:0]        rate_limit_reg;
   logic [REG_W-1:0]        coldstart_limit_reg;
   ccr_tss_t                tss_reg;
   logic [NM_LEN_W-1:0]     nm_len_reg;
   ccr_ctrl_t               ctrl;
   logic                    off_sign_reg;
   logic                    rate_sign_reg;
   logic                    off_en_q;
   logic                    rate_en_q;

   // Startup tracking
   ccr_state_t              state_reg;
   ccr_state_t              state_next;
   logic [REG_W-1:0]        attempt_reg;
   logic [REG_W-1:0]        attempt_next;

   // Outputs
   logic signed [SUM_W-1:0] offset_out_reg;
   logic signed [SUM_W-1:0] rate_out_reg;
   logic                    corr_valid_reg;
   logic                    cs_allowed_reg;
   logic                    listen_reg;
   logic                    comm_reg;

   // Write decode
   wire                     wr_start   = AWVALID && WVALID && !awready_reg && !bvalid_reg;
   wire                     wr_fire    = awready_reg && wready_reg;
   wire                     wr_aligned = (AWADDR[IDX_LSB-1:0] == 2'h0)
                                         && (AWADDR[ADDR_W-1:IDX_W+IDX_LSB] == 2'h0);
   wire [IDX_W-1:0]         wr_idx     = AWADDR[IDX_W+IDX_LSB-1:IDX_LSB];
   wire                     wr_lo      = WSTRB[0];
   wire                     wr_hi      = WSTRB[1];
   wire                     wr_cfg     = wr_fire && wr_aligned && CONFIG_ACTIVE;

   wire                     sel_w_off   = wr_aligned && (wr_idx == IDX_EXT_OFFSET);
   wire                     sel_w_rate  = wr_aligned && (wr_idx == IDX_EXT_RATE);
   wire                     sel_w_ctrl  = wr_aligned && (wr_idx == IDX_EXT_CTRL);
   wire                     sel_w_olim  = wr_aligned && (wr_idx == IDX_OFFSET_LIMIT);
   wire                     sel_w_rlim  = wr_aligned && (wr_idx == IDX_RATE_LIMIT);
   wire                     sel_w_cs    = wr_aligned && (wr_idx == IDX_COLDSTART);
   wire                     sel_w_tss   = wr_aligned && (wr_idx == IDX_START_SEQ);
   wire                     sel_w_nm    = wr_aligned && (wr_idx == IDX_NM_VECTOR);
   wire                     sel_w_stat  = wr_aligned && (wr_idx == IDX_STATUS);
   wire                     wr_mapped   = sel_w_off || sel_w_rate || sel_w_ctrl || sel_w_olim
                                          || sel_w_rlim || sel_w_cs || sel_w_tss || sel_w_nm
                                          || sel_w_stat;
   wire                     ctrl_wr     = wr_fire && sel_w_ctrl && wr_lo;

   // Read decode
   wire                     rd_start   = ARVALID && !arready_reg && !rvalid_reg;
   wire                     rd_fire    = ARVALID && arready_reg;
   wire                     rd_aligned = (ARADDR[IDX_LSB-1:0] == 2'h0)
                                         && (ARADDR[ADDR_W-1:IDX_W+IDX_LSB] == 2'h0);
   wire [IDX_W-1:0]         rd_idx     = ARADDR[IDX_W+IDX_LSB-1:IDX_LSB];
   logic [DATA_W-1:0]       rd_word;
   logic                    rd_hit;

   // Reserved bits read as zero
   always_comb
   begin
      rd_word = '0;
      rd_hit  = rd_aligned;
      unique case (rd_idx)
         IDX_EXT_OFFSET:   rd_word[REG_W-1:0]    = ext_offset_reg;
         IDX_EXT_RATE:     rd_word[REG_W-1:0]    = ext_rate_reg;
         IDX_EXT_CTRL:     rd_word[NM_LEN_W-1:0] = ctrl;
         IDX_OFFSET_LIMIT: rd_word[REG_W-1:0]    = offset_limit_reg;
         IDX_RATE_LIMIT:   rd_word[REG_W-1:0]    = rate_limit_reg;
         IDX_COLDSTART:    rd_word[REG_W-1:0]    = coldstart_limit_reg;
         IDX_START_SEQ:    rd_word[REG_W-1:0]    = tss_reg;
         IDX_NM_VECTOR:    rd_word[NM_LEN_W-1:0] = nm_len_reg;
         IDX_STATUS:
         begin
            rd_word[REG_W-1:0] = attempt_reg;
            rd_word[BIT_LISTEN] = (state_reg == ST_LISTEN);
         end
         default:          rd_hit = 1'b0;
      endcase
   end

   // Write channel handshake
   always_ff @(posedge CLOCK)
   begin
      if (!RST_B)
      begin
         awready_reg <= 1'b0;
         wready_reg  <= 1'b0;
         bvalid_reg  <= 1'b0;
         bresp_reg   <= RESP_OKAY;
      end
      else
      begin
         awready_reg <= wr_start;
         wready_reg  <= wr_start;
         if (wr_fire)
         begin
            bvalid_reg <= 1'b1;
            bresp_reg  <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
         end
         else if (BREADY)
            bvalid_reg <= 1'b0;
      end
   end

   // Read channel handshake
   always_ff @(posedge CLOCK)
   begin
      if (!RST_B)
      begin
         arready_reg <= 1'b0;
         rvalid_reg  <= 1'b0;
         rresp_reg   <= RESP_OKAY;
         rdata_reg   <= '0;
      end
      else
      begin
         arready_reg <= rd_start;
         if (rd_fire)
         begin
            rvalid_reg <= 1'b1;
            rresp_reg  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
            rdata_reg  <= rd_word;
         end
         else if (RREADY)
            rvalid_reg <= 1'b0;
      end
   end

   // Configuration-locked registers
   always_ff @(posedge CLOCK)
   begin
      if (!RST_B)
      begin
         ext_offset_reg      <= RST_REG16;
         ext_rate_reg        <= RST_REG16;
         offset_limit_reg    <= RST_REG16;
         rate_limit_reg      <= RST_REG16;
         coldstart_limit_reg <= RST_REG16;
         tss_reg             <= RST_REG16;
         nm_len_reg          <= RST_NM;
      end
      else if (wr_cfg)
      begin
         if (sel_w_off && wr_lo) ext_offset_reg[7:0]       <= WDATA[7:0];
         if (sel_w_off && wr_hi) ext_offset_reg[15:8]      <= WDATA[15:8];
         if (sel_w_rate && wr_lo) ext_rate_reg[7:0]        <= WDATA[7:0];
         if (sel_w_rate && wr_hi) ext_rate_reg[15:8]       <= WDATA[15:8];
         if (sel_w_olim && wr_lo) offset_limit_reg[7:0]    <= WDATA[7:0];
         if (sel_w_olim && wr_hi) offset_limit_reg[15:8]   <= WDATA[15:8];
         if (sel_w_rlim && wr_lo) rate_limit_reg[7:0]      <= WDATA[7:0];
         if (sel_w_rlim && wr_hi) rate_limit_reg[15:8]     <= WDATA[15:8];
         if (sel_w_cs && wr_lo) coldstart_limit_reg[7:0]   <= WDATA[7:0];
         if (sel_w_cs && wr_hi) coldstart_limit_reg[15:8]  <= WDATA[15:8];
         if (sel_w_tss && wr_lo) tss_reg.tx_len            <= WDATA[7:0];
         if (sel_w_tss && wr_hi) tss_reg.rx_max            <= WDATA[15:8];
         if (sel_w_nm && wr_lo) nm_len_reg                 <= WDATA[NM_LEN_W-1:0];
      end
   end

   // Sign bits: plain read-write at any time
   always_ff @(posedge CLOCK)
   begin
      if (!RST_B)
      begin
         off_sign_reg  <= 1'b0;
         rate_sign_reg <= 1'b0;
      end
      else if (ctrl_wr)
      begin
         off_sign_reg  <= WDATA[BIT_OFF_SIGN];
         rate_sign_reg <= WDATA[BIT_RATE_SIGN];
      end
   end

   // Enable bits: set by host, cleared once applied
   ccr_oneshot u_off_en
   (
      .clk      (CLOCK),
      .rst_b    (RST_B),
      .host_wr  (ctrl_wr),
      .host_bit (WDATA[BIT_OFF_EN]),
      .hw_clr   (DOUBLE_CYCLE_START),
      .q        (off_en_q)
   );

   ccr_oneshot u_rate_en
   (
      .clk      (CLOCK),
      .rst_b    (RST_B),
      .host_wr  (ctrl_wr),
      .host_bit (WDATA[BIT_RATE_EN]),
      .hw_clr   (DOUBLE_CYCLE_START),
      .q        (rate_en_q)
   );

   assign ctrl = {rate_sign_reg, rate_en_q, off_sign_reg, off_en_q};

   // Bound an internal term to plus or minus the limit
   function automatic logic signed [CORR_W-1:0] clamp(input logic signed [CORR_W-1:0] v,
                                                      input logic [REG_W-1:0] lim);
      logic signed [CORR_W-1:0] hi;
      hi = signed'({1'b0, lim});
      if (v > hi)
         clamp = hi;
      else if (v < -hi)
         clamp = -hi;
      else
         clamp = v;
   endfunction : clamp

   wire signed [CORR_W-1:0] off_int_clamped  = clamp(INT_OFFSET_CORR, offset_limit_reg);
   wire signed [CORR_W-1:0] rate_int_clamped = clamp(INT_RATE_CORR, rate_limit_reg);
   wire signed [SUM_W-1:0]  off_ext  = signed'({2'b00, ext_offset_reg});
   wire signed [SUM_W-1:0]  rate_ext = signed'({2'b00, ext_rate_reg});
   wire signed [SUM_W-1:0]  off_ext_term  = !ctrl.off_en ? '0
                                            : (ctrl.off_sign ? -off_ext : off_ext);
   wire signed [SUM_W-1:0]  rate_ext_term = !ctrl.rate_en ? '0
                                            : (ctrl.rate_sign ? -rate_ext : rate_ext);
   // External terms join after the clamp
   wire signed [SUM_W-1:0]  off_sum  = SUM_W'(off_int_clamped) + off_ext_term;
   wire signed [SUM_W-1:0]  rate_sum = SUM_W'(rate_int_clamped) + rate_ext_term;

   always_ff @(posedge CLOCK)
   begin
      if (!RST_B)
      begin
         offset_out_reg <= '0;
         rate_out_reg   <= '0;
         corr_valid_reg <= 1'b0;
      end
      else
      begin
         corr_valid_reg <= DOUBLE_CYCLE_START;
         if (DOUBLE_CYCLE_START)
         begin
            offset_out_reg <= off_sum;
            rate_out_reg   <= rate_sum;
         end
      end
   end

   // Coldstart attempt tracking
   wire limit_hit = (attempt_reg + 16'h0001) >= coldstart_limit_reg;

   always_comb
   begin
      state_next   = state_reg;
      attempt_next = attempt_reg;
      unique case (state_reg)
         ST_CONFIG:
         begin
            attempt_next = '0;
            if (!CONFIG_ACTIVE)
               state_next = (coldstart_limit_reg == '0) ? ST_LISTEN : ST_COLDSTART;
         end
         ST_COLDSTART:
         begin
            if (CONFIG_ACTIVE)
               state_next = ST_CONFIG;
            else if (VALID_RESPONSE)
               attempt_next = '0;
            else if (COLDSTART_ATTEMPT)
            begin
               attempt_next = attempt_reg + 16'h0001;
               if (limit_hit)
                  state_next = ST_LISTEN;
            end
         end
         ST_LISTEN:
         begin
            if (CONFIG_ACTIVE)
               state_next = ST_CONFIG;
         end
         default:
         begin
            state_next   = ST_CONFIG;
            attempt_next = '0;
         end
      endcase
   end

   always_ff @(posedge CLOCK)
   begin
      if (!RST_B)
      begin
         state_reg      <= ST_CONFIG;
         attempt_reg    <= '0;
         cs_allowed_reg <= 1'b0;
         listen_reg     <= 1'b0;
         comm_reg       <= 1'b0;
      end
      else
      begin
         state_reg      <= state_next;
         attempt_reg    <= attempt_next;
         cs_allowed_reg <= (state_next == ST_COLDSTART);
         listen_reg     <= (state_next == ST_LISTEN);
         comm_reg       <= (coldstart_limit_reg != '0);
      end
   end

   assign AWREADY            = awready_reg;
   assign WREADY             = wready_reg;
   assign BVALID             = bvalid_reg;
   assign BRESP              = bresp_reg;
   assign ARREADY            = arready_reg;
   assign RVALID             = rvalid_reg;
   assign RRESP              = rresp_reg;
   assign RDATA              = rdata_reg;
   assign OFFSET_CORR        = offset_out_reg;
   assign RATE_CORR          = rate_out_reg;
   assign CORR_VALID         = corr_valid_reg;
   assign COLDSTART_ALLOWED  = cs_allowed_reg;
   assign INTEGRATION_LISTEN = listen_reg;
   assign COMM_ALLOWED       = comm_reg;
   assign START_SEQ_TX_LEN   = tss_reg.tx_len;
   assign START_SEQ_RX_MAX   = tss_reg.rx_max;
   assign NM_VECTOR_LEN      = nm_len_reg;

   // Checks
   default clocking cb @(posedge CLOCK); endclocking
   default disable iff (!RST_B);

   sequence s_off_apply;
      ctrl.off_en && DOUBLE_CYCLE_START && !ctrl_wr;
   endsequence

   sequence s_rate_apply;
      ctrl.rate_en && DOUBLE_CYCLE_START && !ctrl_wr;
   endsequence

   property p_lock_rate;
      !CONFIG_ACTIVE |=> $stable(ext_rate_reg) && $stable(coldstart_limit_reg);
   endproperty
   a_lock_rate: assert property (p_lock_rate) else $error("locked register changed");

   property p_off_clear;
      s_off_apply |=> !ctrl.off_en && CORR_VALID;
   endproperty
   a_off_clear: assert property (p_off_clear) else $error("offset enable not cleared");

   property p_rate_clear;
      s_rate_apply |=> !ctrl.rate_en ##1 (!ctrl.rate_en || $past(ctrl_wr));
   endproperty
   a_rate_clear: assert property (p_rate_clear) else $error("rate enable not cleared");

   property p_set_wins;
      ctrl_wr && WDATA[BIT_OFF_EN] && DOUBLE_CYCLE_START |=> ctrl.off_en;
   endproperty
   a_set_wins: assert property (p_set_wins) else $error("host set lost");

   property p_zero_limit;
      (coldstart_limit_reg == '0) ##1 (coldstart_limit_reg == '0) |=> !COLDSTART_ALLOWED && !COMM_ALLOWED;
   endproperty
   a_zero_limit: assert property (p_zero_limit) else $error("start with zero limit");

   property p_listen_hold;
      (state_reg == ST_LISTEN) && !CONFIG_ACTIVE |=> (state_reg == ST_LISTEN) ##1 !COLDSTART_ALLOWED;
   endproperty
   a_listen_hold: assert property (p_listen_hold) else $error("left listen early");

   property p_off_clamp;
      DOUBLE_CYCLE_START && !ctrl.off_en && (INT_OFFSET_CORR > signed'({1'b0, offset_limit_reg}))
         |=> OFFSET_CORR == signed'({2'b00, $past(offset_limit_reg)});
   endproperty
   a_off_clamp: assert property (p_off_clamp) else $error("offset not clamped");

   property p_ext_unbounded;
      DOUBLE_CYCLE_START && ctrl.off_en && !ctrl.off_sign && (INT_OFFSET_CORR == '0)
         |=> OFFSET_CORR == signed'({2'b00, $past(ext_offset_reg)});
   endproperty
   a_ext_unbounded: assert property (p_ext_unbounded) else $error("external term altered");

endmodule : ccr_regs
`default_nettype wire

// File: rtl/ccr_pkg.sv
// Purpose: Shared constants and types for the correction and startup configuration bank
// Assumes: AXI4-Lite, 32-bit data, one word per register
// Notes:   Register indices are word indices; byte address is index times four
package ccr_pkg;

   localparam int          ADDR_W           = 12;
   localparam int          DATA_W           = 32;
   localparam int          IDX_W            = 8;
   localparam int          IDX_LSB          = 2;
   localparam int          REG_W            = 16;
   localparam int          NM_LEN_W         = 4;
   localparam int          TSS_W            = 8;
   localparam int          CORR_W           = 17;
   localparam int          SUM_W            = 18;

   localparam logic [IDX_W-1:0] IDX_NM_VECTOR    = 8'h3e;
   localparam logic [IDX_W-1:0] IDX_START_SEQ    = 8'hba;
   localparam logic [IDX_W-1:0] IDX_COLDSTART    = 8'hc0;
   localparam logic [IDX_W-1:0] IDX_OFFSET_LIMIT = 8'hda;
   localparam logic [IDX_W-1:0] IDX_RATE_LIMIT   = 8'hdc;
   localparam logic [IDX_W-1:0] IDX_EXT_OFFSET   = 8'hf4;
   localparam logic [IDX_W-1:0] IDX_EXT_RATE     = 8'hf6;
   localparam logic [IDX_W-1:0] IDX_EXT_CTRL     = 8'hf8;
   localparam logic [IDX_W-1:0] IDX_STATUS       = 8'hfc;

   localparam int          BIT_OFF_EN       = 0;
   localparam int          BIT_OFF_SIGN     = 1;
   localparam int          BIT_RATE_EN      = 2;
   localparam int          BIT_RATE_SIGN    = 3;
   localparam int          BIT_LISTEN       = 16;

   localparam logic [REG_W-1:0]    RST_REG16 = 16'h0000;
   localparam logic [NM_LEN_W-1:0] RST_NM    = 4'h0;
   localparam logic [1:0]          RESP_OKAY   = 2'b00;
   localparam logic [1:0]          RESP_SLVERR = 2'b10;

   typedef struct packed {
      logic rate_sign;
      logic rate_en;
      logic off_sign;
      logic off_en;
   } ccr_ctrl_t;

   typedef struct packed {
      logic [TSS_W-1:0] rx_max;
      logic [TSS_W-1:0] tx_len;
   } ccr_tss_t;

   typedef enum logic [2:0] {
      ST_CONFIG    = 3'b001,
      ST_COLDSTART = 3'b010,
      ST_LISTEN    = 3'b100
   } ccr_state_t;

endpackage : ccr_pkg

// File: rtl/ccr_oneshot.sv
// Purpose: Host-set, hardware-cleared request bit
// Assumes: Same clock as the register bank
// Notes:   A host write in the clearing cycle wins
`timescale 1ns/1ps
`default_nettype none
module ccr_oneshot
   import ccr_pkg::*;
(
   input  wire logic clk,
   input  wire logic rst_b,
   input  wire logic host_wr,
   input  wire logic host_bit,
   input  wire logic hw_clr,
   output logic      q
);

   logic q_reg;
   logic q_next;

   // Host write first, then the automatic clear
   assign q_next = host_wr ? host_bit : (hw_clr ? 1'b0 : q_reg);

   always_ff @(posedge clk)
   begin
      if (!rst_b)
         q_reg <= 1'b0;
      else
         q_reg <= q_next;
   end

   assign q = q_reg;

endmodule : ccr_oneshot
`default_nettype wire

// File: testbench/ccr_engine_model.sv
// Purpose: Protocol engine stand-in for state, timing and correction inputs
// Assumes: Shares the bench clock
// Notes:   Pulses last one cycle
`timescale 1ns/1ps
`default_nettype none
module ccr_engine_model
   import ccr_pkg::*;
(
   input  wire logic                clk,
   output logic                     cfg,
   output logic                     dcs,
   output logic                     att,
   output logic                     vr,
   output logic signed [CORR_W-1:0] io,
   output logic signed [CORR_W-1:0] ir
);
   initial
   begin
      cfg = 1'h1;
      dcs = 1'h0;
      att = 1'h0;
      vr  = 1'h0;
      io  = '0;
      ir  = '0;
   end
   // Double cycle start with fresh internal terms
   task automatic cycle(input logic signed [CORR_W-1:0] o, input logic signed [CORR_W-1:0] r);
      @(posedge clk);
      io  <= o;
      ir  <= r;
      dcs <= 1'h1;
      @(posedge clk);
      dcs <= 1'h0;
   endtask : cycle
   task automatic try_start();
      @(posedge clk);
      att <= 1'h1;
      @(posedge clk);
      att <= 1'h0;
   endtask : try_start
   // Valid response from another node
   task automatic respond();
      @(posedge clk);
      vr <= 1'h1;
      @(posedge clk);
      vr <= 1'h0;
   endtask : respond
   task automatic set_cfg(input logic v);
      @(posedge clk);
      cfg <= v;
   endtask : set_cfg
endmodule : ccr_engine_model
`default_nettype wire

// File: testbench/ccr_regs_tb_top.sv
// Purpose: Self-checking bench for the correction and startup registers
// Assumes: Bus answers within 50 cycles
// Notes:   Byte address is four times the index
`timescale 1ns/1ps
`default_nettype none
module ccr_regs_tb_top;
   import ccr_pkg::*;
   logic                     clock, rst_b, awvalid, wvalid, bready, arvalid, rready, awready, wready;
   logic                     bvalid, arready, rvalid, corr_valid, cs_ok, listen, comm_ok, cfg, dcs, att, vr;
   logic [ADDR_W-1:0]        awaddr, araddr;
   logic [DATA_W-1:0]        wdata, rdata;
   logic [1:0]               bresp, rresp;
   logic signed [CORR_W-1:0] io, ir;
   logic signed [SUM_W-1:0]  off_c, rate_c;
   logic [TSS_W-1:0]         tx_len, rx_max;
   logic [NM_LEN_W-1:0]      nm_len;
   logic [DATA_W/8-1:0]      wstrb;
   int                       miscompares, comparisons, i;
   logic [IDX_W-1:0]         locked [6] = '{IDX_START_SEQ, IDX_COLDSTART, IDX_OFFSET_LIMIT, IDX_RATE_LIMIT,
                                            IDX_EXT_OFFSET, IDX_EXT_RATE};
   logic [REG_W-1:0]         vals [6] = '{16'h0c05, 16'h0002, 16'h0005, 16'h0003, 16'h0010, 16'h0020};
   ccr_engine_model i_ccr_engine_model (.clk(clock), .cfg(cfg), .dcs(dcs), .att(att), .vr(vr), .io(io), .ir(ir));
   ccr_regs i_ccr_regs (.CLOCK(clock), .RST_B(rst_b), .AWADDR(awaddr), .AWVALID(awvalid), .AWREADY(awready),
      .WDATA(wdata), .WSTRB(wstrb), .WVALID(wvalid), .WREADY(wready), .BRESP(bresp), .BVALID(bvalid),
      .BREADY(bready), .ARADDR(araddr), .ARVALID(arvalid), .ARREADY(arready), .RDATA(rdata), .RRESP(rresp),
      .RVALID(rvalid), .RREADY(rready), .CONFIG_ACTIVE(cfg), .DOUBLE_CYCLE_START(dcs), .INT_OFFSET_CORR(io),
      .INT_RATE_CORR(ir), .COLDSTART_ATTEMPT(att), .VALID_RESPONSE(vr), .OFFSET_CORR(off_c),
      .RATE_CORR(rate_c), .CORR_VALID(corr_valid), .COLDSTART_ALLOWED(cs_ok), .INTEGRATION_LISTEN(listen),
      .COMM_ALLOWED(comm_ok), .START_SEQ_TX_LEN(tx_len), .START_SEQ_RX_MAX(rx_max), .NM_VECTOR_LEN(nm_len));
   always #50 clock = ~clock;
   task automatic summarize();
      $display("comparisons %0d miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : summarize
   task automatic check(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic tmo(input int n);
      if (n >= 50)
      begin
         miscompares++;
         summarize();
      end
   endtask : tmo
   task automatic wr(input logic [IDX_W-1:0] idx, input logic [REG_W-1:0] d, input logic [1:0] er);
      int n;
      @(posedge clock);
      awaddr  <= ADDR_W'({idx, 2'h0});
      wdata   <= DATA_W'(d);
      awvalid <= 1'h1;
      wvalid  <= 1'h1;
      bready  <= 1'h1;
      n = 0;
      @(posedge clock);
      while ((awready !== 1'h1 || wready !== 1'h1) && n++ < 50)
         @(posedge clock);
      awvalid <= 1'h0;
      wvalid  <= 1'h0;
      while (bvalid !== 1'h1 && n++ < 50)
         @(posedge clock);
      tmo(n);
      check(bresp, er);
      bready <= 1'h0;
   endtask : wr
   task automatic rd(input logic [IDX_W-1:0] idx, input logic [DATA_W-1:0] ed, input logic [1:0] er);
      int n;
      @(posedge clock);
      araddr  <= ADDR_W'({idx, 2'h0});
      arvalid <= 1'h1;
      rready  <= 1'h1;
      n = 0;
      @(posedge clock);
      while (arready !== 1'h1 && n++ < 50)
         @(posedge clock);
      arvalid <= 1'h0;
      while (rvalid !== 1'h1 && n++ < 50)
         @(posedge clock);
      tmo(n);
      check(rdata, ed);
      check(rresp, er);
      rready <= 1'h0;
   endtask : rd
   // One double cycle, then the applied corrections
   task automatic dc(input int o, input int r, input logic [DATA_W-1:0] eo, input logic [DATA_W-1:0] er);
      i_ccr_engine_model.cycle(CORR_W'(o), CORR_W'(r));
      @(posedge clock);
      check(corr_valid, 32'h1);
      check(off_c, eo);
      check(rate_c, er);
   endtask : dc
   initial
   begin
      {clock, rst_b, awvalid, wvalid, bready, arvalid, rready, awaddr, araddr, wdata} = '0;
      wstrb = 4'hf;
      repeat (5) @(posedge clock);
      rst_b <= 1'h1;
      rd(IDX_EXT_CTRL, 32'h0, RESP_OKAY);
      rd(IDX_NM_VECTOR, 32'h0, RESP_OKAY);
      wr(IDX_NM_VECTOR, 16'hfffc, RESP_OKAY);
      rd(IDX_NM_VECTOR, 32'hc, RESP_OKAY);
      rd(8'h10, 32'h0, RESP_SLVERR);
      wstrb <= 4'h2;
      wr(IDX_EXT_OFFSET, 16'h1234, RESP_OKAY);
      wstrb <= 4'hf;
      rd(IDX_EXT_OFFSET, 32'h1200, RESP_OKAY);
      for (i = 0; i < 6; i++)
      begin
         wr(locked[i], vals[i], RESP_OKAY);
         rd(locked[i], DATA_W'(vals[i]), RESP_OKAY);
      end
      check({tx_len, rx_max, nm_len}, 32'h50cc);
      i_ccr_engine_model.set_cfg(1'h0);
      for (i = 0; i < 6; i++)
      begin
         wr(locked[i], ~vals[i], RESP_OKAY);
         rd(locked[i], DATA_W'(vals[i]), RESP_OKAY);
      end
      check({cs_ok, comm_ok, listen}, 32'h6);
      wr(IDX_EXT_CTRL, 16'h0007, RESP_OKAY);
      dc(100, -50, 32'hfffffff5, 32'h1d);
      rd(IDX_EXT_CTRL, 32'h2, RESP_OKAY);
      // Control write lands on the double cycle start edge
      fork
         wr(IDX_EXT_CTRL, 16'h000d, RESP_OKAY);
         begin
            @(posedge clock);
            dc(-100, 2, 32'hfffffffb, 32'h2);
         end
      join
      dc(0, 0, 32'h10, 32'hffffffe0);
      dc(200, -9, 32'h5, 32'hfffffffd);
      i_ccr_engine_model.try_start();
      repeat (2) @(posedge clock);
      check(listen, 32'h0);
      i_ccr_engine_model.respond();
      rd(IDX_STATUS, 32'h0, RESP_OKAY);
      i_ccr_engine_model.try_start();
      i_ccr_engine_model.try_start();
      repeat (2) @(posedge clock);
      check({cs_ok, listen}, 32'h1);
      rd(IDX_STATUS, 32'h10002, RESP_OKAY);
      i_ccr_engine_model.set_cfg(1'h1);
      i_ccr_engine_model.set_cfg(1'h0);
      repeat (2) @(posedge clock);
      check({cs_ok, listen}, 32'h2);
      i_ccr_engine_model.set_cfg(1'h1);
      wr(IDX_COLDSTART, 16'h0000, RESP_OKAY);
      i_ccr_engine_model.set_cfg(1'h0);
      repeat (2) @(posedge clock);
      check({comm_ok, listen}, 32'h1);
      summarize();
   end
endmodule : ccr_regs_tb_top
`default_nettype wire
